// file: ppss_cfg.svh
// register map, field positions and reset values of the strap selection block
`ifndef PPSS_CFG_SVH
`define PPSS_CFG_SVH

// ==========================================================================
// register byte offsets
`define PPSS_OFS_STATUS    8'h00
`define PPSS_OFS_GPIO_EN   8'h04
`define PPSS_OFS_GPIO_DIR  8'h08
`define PPSS_OFS_GPIO_OUT  8'h0c
`define PPSS_OFS_GPIO_IN   8'h10

// ==========================================================================
// status register field positions
`define PPSS_ST_CELL_CAP    0
`define PPSS_ST_PCI_CAP     1
`define PPSS_ST_SER2_CAP    2
`define PPSS_ST_AUTOI_CAP   3
`define PPSS_ST_SER2_LIVE   4
`define PPSS_ST_SER1_EN     5
`define PPSS_ST_CELL_EN     6
`define PPSS_ST_HOST_EN     7
`define PPSS_ST_PCI_EN      8
`define PPSS_ST_EEPROM_EN   9
`define PPSS_ST_SER2_EN     10
`define PPSS_ST_PCI_DEFAULT 11
`define PPSS_ST_CAPTURED    12

// ==========================================================================
// gpio layout and reset values
`define PPSS_GPIO_UPPER_LO  9
`define PPSS_GPIO_EN_RST    16'h0000
`define PPSS_GPIO_DIR_RST   16'h0000
`define PPSS_GPIO_OUT_RST   16'h0000

`endif

// file: ppss_pkg.sv
// types shared by the strap selection block
package ppss_pkg;

  // ==========================================================================
  // one-hot phase of the strap capture
  typedef enum logic [1:0] {
    PH_CAPTURE = 2'b01,
    PH_RUN     = 2'b10
  } ppss_phase_e;

  // ==========================================================================
  // strap levels as captured
  typedef struct packed {
    logic cell_port_select_strap;
    logic pci_select_strap;
    logic serial2_select_strap;
    logic eeprom_autoinit_strap;
  } ppss_strap_s;

  // ==========================================================================
  // peripheral enables handed to the rest of the chip
  typedef struct packed {
    logic serial_port_1;
    logic cell_port;
    logic host_port;
    logic pci;
    logic eeprom;
    logic serial_port_2;
    logic pci_use_defaults;
    logic serial_port_0;
    logic timers;
  } ppss_enable_s;

  // ==========================================================================
  // whole state of the block apart from the reset and input synchronisers
  typedef struct packed {
    ppss_phase_e phase;
    ppss_strap_s cap;
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] gp_en;
    logic [15:0] gp_dir;
    logic [15:0] gp_out;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic        be0_out;
    logic        be0_oe;
    logic        cs_out;
    logic        cs_oe;
    logic        autoinit_go;
  } ppss_state_s;

endpackage

// file: ppss_straps.sv
// strap capture, peripheral selection and shared pin steering
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ppss_cfg.svh"

module ppss_straps (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // strap pins
  input  wire logic                 cell_port_strap_pin,
  input  wire logic                 pci_select_strap_pin,
  input  wire logic                 serial2_select_strap_pin,
  input  wire logic                 autoinit_strap_pin,
  // avalon-mm slave
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // pci core drive of the shared pins
  input  wire logic [6:0]           pci_gpio_out,
  input  wire logic [6:0]           pci_gpio_oe,
  input  wire logic                 pci_byte_enable_zero_out,
  input  wire logic                 pci_byte_enable_zero_oe,
  input  wire logic                 pci_eeprom_cs_out,
  // gpio pins, lower_gpio_pins are [8:0], upper_gpio_pins are [15:9]
  input  wire logic [15:0]          gpio_pin_in,
  output logic [15:0]               gpio_pin_out,
  output logic [15:0]               gpio_pin_oe,
  // pci-only pins
  output logic                      pci_byte_enable_zero_pin_out,
  output logic                      pci_byte_enable_zero_pin_oe,
  output logic                      eeprom_chip_select_pin_out,
  output logic                      eeprom_chip_select_pin_oe,
  // selection results
  output ppss_pkg::ppss_enable_s    periph_enable,
  output logic                      pci_autoinit_start
);

  // ==========================================================================
  // reset release and input synchronisers
  logic [1:0]  rst_pipe;
  logic        rst_n;
  logic [3:0]  strap_meta;
  logic [3:0]  strap_sync;
  logic [15:0] gpio_meta;
  logic [15:0] gpio_sync;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // the strap synchronisers keep running through reset so that the level
  // present while reset is held reaches the capture stage
  always_ff @(posedge ref_clk) begin
    strap_meta <= {cell_port_strap_pin, pci_select_strap_pin,
                   serial2_select_strap_pin, autoinit_strap_pin};
    strap_sync <= strap_meta;
    gpio_meta  <= gpio_pin_in;
    gpio_sync  <= gpio_meta;
  end

  // ==========================================================================
  // helpers
  function automatic logic [15:0] merge_be(input logic [15:0] old_v,
                                           input logic [31:0] wdata,
                                           input logic [3:0]  be);
    logic [15:0] v;
    v = old_v;
    if (be[0]) begin
      v[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      v[15:8] = wdata[15:8];
    end
    return v;
  endfunction

  // ==========================================================================
  // selection logic
  ppss_pkg::ppss_state_s  st_reg;
  ppss_pkg::ppss_state_s  st_next;
  ppss_pkg::ppss_strap_s  strap_now;
  logic                   run;
  logic                   serial2_live;
  logic                   eeprom_on;
  logic [31:0]            status_word;
  logic                   access;
  logic [6:0]             upper_gpio_drive;

  assign strap_now    = ppss_pkg::ppss_strap_s'(strap_sync);
  assign run          = (st_reg.phase == ppss_pkg::PH_RUN);
  assign serial2_live = strap_now.serial2_select_strap;

  always_comb begin
    periph_enable = '0;
    if (run) begin
      periph_enable.serial_port_1    = !st_reg.cap.cell_port_select_strap;
      periph_enable.cell_port        = st_reg.cap.cell_port_select_strap;
      periph_enable.host_port        = !st_reg.cap.pci_select_strap;
      periph_enable.pci              = st_reg.cap.pci_select_strap;
      periph_enable.serial_port_2    = !(st_reg.cap.pci_select_strap
                                         && !serial2_live);
      periph_enable.eeprom           = st_reg.cap.pci_select_strap
                                       && !serial2_live;
      periph_enable.pci_use_defaults = st_reg.cap.pci_select_strap
                                       && !st_reg.cap.eeprom_autoinit_strap;
      periph_enable.serial_port_0    = 1'b1;
      periph_enable.timers           = 1'b1;
    end
  end
  assign eeprom_on = periph_enable.eeprom;

  always_comb begin
    status_word = '0;
    status_word[`PPSS_ST_CELL_CAP]    = st_reg.cap.cell_port_select_strap;
    status_word[`PPSS_ST_PCI_CAP]     = st_reg.cap.pci_select_strap;
    status_word[`PPSS_ST_SER2_CAP]    = st_reg.cap.serial2_select_strap;
    status_word[`PPSS_ST_AUTOI_CAP]   = st_reg.cap.eeprom_autoinit_strap;
    status_word[`PPSS_ST_SER2_LIVE]   = serial2_live;
    status_word[`PPSS_ST_SER1_EN]     = periph_enable.serial_port_1;
    status_word[`PPSS_ST_CELL_EN]     = periph_enable.cell_port;
    status_word[`PPSS_ST_HOST_EN]     = periph_enable.host_port;
    status_word[`PPSS_ST_PCI_EN]      = periph_enable.pci;
    status_word[`PPSS_ST_EEPROM_EN]   = periph_enable.eeprom;
    status_word[`PPSS_ST_SER2_EN]     = periph_enable.serial_port_2;
    status_word[`PPSS_ST_PCI_DEFAULT] = periph_enable.pci_use_defaults;
    status_word[`PPSS_ST_CAPTURED]    = run;
  end

  assign access           = avs_read || avs_write;
  assign upper_gpio_drive = st_reg.gp_en[15:9] & st_reg.gp_dir[15:9];

  always_comb begin
    st_next             = st_reg;
    st_next.autoinit_go = 1'b0;
    // capture once, right after reset release, from levels sampled during reset
    if (st_reg.phase == ppss_pkg::PH_CAPTURE) begin
      st_next.cap   = strap_now;
      st_next.phase = ppss_pkg::PH_RUN;
      st_next.autoinit_go = strap_now.pci_select_strap
                            && !strap_now.serial2_select_strap
                            && strap_now.eeprom_autoinit_strap;
    end
    // captured straps are otherwise left untouched until the next reset

    // one wait state: the answer is registered before waitrequest drops
    st_next.ack = access && !st_reg.ack;
    if (access && !st_reg.ack) begin
      st_next.rdata = '0;
      if (avs_read) begin
        if (avs_address == `PPSS_OFS_STATUS) begin
          st_next.rdata = status_word;
        end else if (avs_address == `PPSS_OFS_GPIO_EN) begin
          st_next.rdata = {16'h0000, st_reg.gp_en};
        end else if (avs_address == `PPSS_OFS_GPIO_DIR) begin
          st_next.rdata = {16'h0000, st_reg.gp_dir};
        end else if (avs_address == `PPSS_OFS_GPIO_OUT) begin
          st_next.rdata = {16'h0000, st_reg.gp_out};
        end else if (avs_address == `PPSS_OFS_GPIO_IN) begin
          st_next.rdata = {16'h0000, gpio_sync};
        end
      end
    end
    if (avs_write && st_reg.ack) begin
      if (avs_address == `PPSS_OFS_GPIO_EN) begin
        st_next.gp_en = merge_be(st_reg.gp_en, avs_writedata, avs_byteenable);
      end else if (avs_address == `PPSS_OFS_GPIO_DIR) begin
        st_next.gp_dir = merge_be(st_reg.gp_dir, avs_writedata, avs_byteenable);
      end else if (avs_address == `PPSS_OFS_GPIO_OUT) begin
        st_next.gp_out = merge_be(st_reg.gp_out, avs_writedata, avs_byteenable);
      end
    end

    // pin steering, registered so pins never glitch on decode changes
    st_next.pin_out = '0;
    st_next.pin_oe  = '0;
    st_next.be0_out = 1'b0;
    st_next.be0_oe  = 1'b0;
    st_next.cs_out  = 1'b0;
    st_next.cs_oe   = 1'b0;
    if (run) begin
      st_next.pin_out[8:0] = st_reg.gp_out[8:0];
      st_next.pin_oe[8:0]  = st_reg.gp_en[8:0] & st_reg.gp_dir[8:0];
      if (st_reg.cap.pci_select_strap) begin
        st_next.pin_out[15:9] = pci_gpio_out;
        st_next.pin_oe[15:9]  = pci_gpio_oe;
        st_next.be0_out       = pci_byte_enable_zero_out;
        st_next.be0_oe        = pci_byte_enable_zero_oe;
        st_next.cs_out        = pci_eeprom_cs_out;
        st_next.cs_oe         = eeprom_on;
      end else begin
        // pci-only pins stay floating in this branch
        st_next.pin_out[15:9] = st_reg.gp_out[15:9];
        st_next.pin_oe[15:9]  = upper_gpio_drive;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg             <= '0;
      st_reg.phase       <= ppss_pkg::PH_CAPTURE;
      st_reg.gp_en       <= `PPSS_GPIO_EN_RST;
      st_reg.gp_dir      <= `PPSS_GPIO_DIR_RST;
      st_reg.gp_out      <= `PPSS_GPIO_OUT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs
  assign avs_waitrequest              = access && !st_reg.ack;
  assign avs_readdata                 = st_reg.rdata;
  assign gpio_pin_out                 = st_reg.pin_out;
  assign gpio_pin_oe                  = st_reg.pin_oe;
  assign pci_byte_enable_zero_pin_out = st_reg.be0_out;
  assign pci_byte_enable_zero_pin_oe  = st_reg.be0_oe;
  assign eeprom_chip_select_pin_out   = st_reg.cs_out;
  assign eeprom_chip_select_pin_oe    = st_reg.cs_oe;
  assign pci_autoinit_start           = st_reg.autoinit_go;

  // ==========================================================================
  // checks
  sequence s_capture_edge;
    rst_n && (st_reg.phase == ppss_pkg::PH_CAPTURE);  // not at the release edge itself
  endsequence

  sequence s_autoinit_case;
    strap_now.pci_select_strap && !strap_now.serial2_select_strap
      && strap_now.eeprom_autoinit_strap;
  endsequence

  property p_cell_off;
    @(posedge ref_clk) disable iff (!rst_n)
      run && !st_reg.cap.cell_port_select_strap
        |-> periph_enable.serial_port_1 && !periph_enable.cell_port;
  endproperty
  a_cell_off: assert property (p_cell_off) else $error("cell strap 0 selection wrong");

  property p_cell_on;
    @(posedge ref_clk) disable iff (!rst_n)
      run && st_reg.cap.cell_port_select_strap
        |-> periph_enable.cell_port && !periph_enable.serial_port_1;
  endproperty
  a_cell_on: assert property (p_cell_on) else $error("cell strap 1 selection wrong");

  property p_host_sel;
    @(posedge ref_clk) disable iff (!rst_n)
      run && !st_reg.cap.pci_select_strap
        |-> periph_enable.host_port && !periph_enable.pci && !periph_enable.eeprom;
  endproperty
  a_host_sel: assert property (p_host_sel) else $error("host port selection wrong");

  property p_pci_pins_float;
    @(posedge ref_clk) disable iff (!rst_n)
      run && !st_reg.cap.pci_select_strap
        |=> !pci_byte_enable_zero_pin_oe && !eeprom_chip_select_pin_oe;
  endproperty
  a_pci_pins_float: assert property (p_pci_pins_float) else $error("pci pin driven");

  property p_upper_gpio;
    @(posedge ref_clk) disable iff (!rst_n)
      run && !st_reg.cap.pci_select_strap
        |=> gpio_pin_oe[15:9] == $past(upper_gpio_drive);
  endproperty
  a_upper_gpio: assert property (p_upper_gpio) else $error("upper gpio driven unset");

  property p_serial2;
    @(posedge ref_clk) disable iff (!rst_n)
      run |-> periph_enable.serial_port_2
              == !(st_reg.cap.pci_select_strap && !serial2_live);
  endproperty
  a_serial2: assert property (p_serial2) else $error("serial port 2 enable wrong");

  property p_autoinit;
    @(posedge ref_clk) disable iff (!rst_n)
      s_capture_edge ##0 s_autoinit_case |=> pci_autoinit_start ##1 !pci_autoinit_start;
  endproperty
  a_autoinit: assert property (p_autoinit) else $error("autoinit pulse missing");

  property p_ser2_raise;
    @(posedge ref_clk) disable iff (!rst_n)
      run && st_reg.cap.pci_select_strap && $rose(serial2_live)
        |-> periph_enable.serial_port_2 ##1 !eeprom_chip_select_pin_oe;
  endproperty
  a_ser2_raise: assert property (p_ser2_raise) else $error("serial 2 raise not followed");

  property p_defaults;
    @(posedge ref_clk) disable iff (!rst_n)
      run && st_reg.cap.pci_select_strap && !st_reg.cap.eeprom_autoinit_strap
        |-> periph_enable.pci_use_defaults && !pci_autoinit_start;
  endproperty
  a_defaults: assert property (p_defaults) else $error("pci defaults not chosen");

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      run |=> $stable(st_reg.cap) && run;
  endproperty
  a_hold: assert property (p_hold) else $error("captured strap changed");

  property p_always_on;
    @(posedge ref_clk) disable iff (!rst_n)
      run |-> periph_enable.serial_port_0 && periph_enable.timers;
  endproperty
  a_always_on: assert property (p_always_on) else $error("always-on block off");

endmodule
`default_nettype wire

// file: ppss_board_straps.sv
// board-side model of the strap resistors and the controller that drives them
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// strap driver as seen at the device pins
module ppss_board_straps (
  // device reset as seen by the board controller
  input  wire logic                  arst_n,
  // levels the scenario asks for
  input  wire ppss_pkg::ppss_strap_s want,
  // strap pins, always driven to a valid level
  output logic                       cell_port_strap_pin,
  output logic                       pci_select_strap_pin,
  output logic                       serial2_select_strap_pin,
  output logic                       autoinit_strap_pin
);
  logic pci_hold;

  // the pci level is taken only while the device sits in reset, so it never moves in operation
  always_latch begin
    if (!arst_n) begin
      pci_hold <= want.pci_select_strap;
    end
  end

  always_comb begin
    cell_port_strap_pin      = want.cell_port_select_strap;
    pci_select_strap_pin     = pci_hold;
    serial2_select_strap_pin = want.serial2_select_strap;
    autoinit_strap_pin       = want.eeprom_autoinit_strap;
  end
endmodule

`default_nettype wire

// file: tb_top.sv
// self-checking testbench of the strap selection block
`timescale 1ns/1ps
`default_nettype none
`include "ppss_cfg.svh"

module tb_top;
  // ==========================================================================
  // signals
  logic                   ref_clk;
  logic                   arst_n;
  ppss_pkg::ppss_strap_s  want;
  ppss_pkg::ppss_strap_s  st;
  logic                   cell_pin, pci_pin, ser2_pin, ai_pin;
  logic [7:0]             avs_address;
  logic                   avs_read, avs_write, avs_waitrequest;
  logic [31:0]            avs_writedata, avs_readdata;
  logic [3:0]             avs_byteenable;
  logic [6:0]             pci_gpio_out, pci_gpio_oe;
  logic                   pci_be0_out, pci_be0_oe, pci_cs_out;
  logic [15:0]            gpio_pin_in, gpio_pin_out, gpio_pin_oe;
  logic                   be0_out, be0_oe, cs_out, cs_oe;
  ppss_pkg::ppss_enable_s periph_enable;
  ppss_pkg::ppss_enable_s e_v;
  logic                   pci_autoinit_start;
  logic [15:0]            en_v, dir_v, out_v, oe_x, out_x;
  int                     err_total, tests_run, pulses;
  logic [31:0]            exp_q[$];
  string                  name_q[$];

  ppss_board_straps board_i (.arst_n(arst_n), .want(want), .cell_port_strap_pin(cell_pin),
    .pci_select_strap_pin(pci_pin), .serial2_select_strap_pin(ser2_pin),
    .autoinit_strap_pin(ai_pin));

  ppss_straps ppss_straps_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .cell_port_strap_pin(cell_pin), .pci_select_strap_pin(pci_pin),
    .serial2_select_strap_pin(ser2_pin), .autoinit_strap_pin(ai_pin),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pci_gpio_out(pci_gpio_out), .pci_gpio_oe(pci_gpio_oe),
    .pci_byte_enable_zero_out(pci_be0_out), .pci_byte_enable_zero_oe(pci_be0_oe),
    .pci_eeprom_cs_out(pci_cs_out), .gpio_pin_in(gpio_pin_in),
    .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe),
    .pci_byte_enable_zero_pin_out(be0_out), .pci_byte_enable_zero_pin_oe(be0_oe),
    .eeprom_chip_select_pin_out(cs_out), .eeprom_chip_select_pin_oe(cs_oe),
    .periph_enable(periph_enable), .pci_autoinit_start(pci_autoinit_start));

  // ==========================================================================
  // compare, verdict and expectations
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic ppss_pkg::ppss_enable_s en_exp(ppss_pkg::ppss_strap_s s, logic live);
    ppss_pkg::ppss_enable_s e;
    e.serial_port_1    = ~s.cell_port_select_strap;
    e.cell_port        = s.cell_port_select_strap;
    e.host_port        = ~s.pci_select_strap;
    e.pci              = s.pci_select_strap;
    e.eeprom           = s.pci_select_strap & ~live;
    e.serial_port_2    = ~(s.pci_select_strap & ~live);
    e.pci_use_defaults = s.pci_select_strap & ~s.eeprom_autoinit_strap;
    e.serial_port_0    = 1'b1;
    e.timers           = 1'b1;
    return e;
  endfunction

  function automatic logic [31:0] status_exp(ppss_pkg::ppss_strap_s s, logic live);
    ppss_pkg::ppss_enable_s e;
    e = en_exp(s, live);
    return {19'h0, 1'b1, e.pci_use_defaults, e.serial_port_2, e.eeprom, e.pci, e.host_port,
            e.cell_port, e.serial_port_1, live, s.eeprom_autoinit_strap,
            s.serial2_select_strap, s.pci_select_strap, s.cell_port_select_strap};
  endfunction

  // ==========================================================================
  // avalon master, entered right after a rising edge
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic bus_read(input logic [7:0] a, input logic [31:0] exp, input string what);
    exp_q.push_back(exp);
    name_q.push_back(what);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  // read data is taken at the accepting edge, before that edge's updates land
  always @(posedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("unexpected read", 32'h1, 32'h0);
      end else begin
        check(name_q.pop_front(), avs_readdata, exp_q.pop_front());
      end
    end
  end

  always @(posedge ref_clk) begin
    if (pci_autoinit_start === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  task automatic do_reset(input ppss_pkg::ppss_strap_s s);
    want <= s;
    arst_n <= 1'b0;
    pci_gpio_out <= 7'($urandom);
    pci_gpio_oe <= 7'($urandom);
    pci_be0_out <= 1'($urandom);
    pci_be0_oe <= 1'($urandom);
    pci_cs_out <= 1'($urandom);
    gpio_pin_in <= 16'($urandom);
    repeat (4) @(posedge ref_clk);
    pulses = 0;
    arst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask

  // ==========================================================================
  // clock, watchdog and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end

  initial begin
    arst_n = 1'b0;
    want = '0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    pci_gpio_out = 7'h00;
    pci_gpio_oe = 7'h00;
    pci_be0_out = 1'b0;
    pci_be0_oe = 1'b0;
    pci_cs_out = 1'b0;
    gpio_pin_in = 16'h0000;
    err_total = 0;
    tests_run = 0;
    pulses = 0;
    void'($urandom(63138));
    @(posedge ref_clk);
    // every strap combination, each behind its own reset
    for (int i = 0; i < 16; i++) begin
      st = ppss_pkg::ppss_strap_s'(i[3:0]);
      do_reset(st);
      @(negedge ref_clk);
      e_v = en_exp(st, st.serial2_select_strap);
      oe_x = st.pci_select_strap ? {pci_gpio_oe, 9'h000} : 16'h0000;
      check("autoinit pulses", 32'(pulses), 32'(e_v.eeprom & st.eeprom_autoinit_strap));
      check("enables", 32'(periph_enable), 32'(e_v));
      check("be0 oe", 32'(be0_oe), 32'(st.pci_select_strap & pci_be0_oe));
      check("be0 out", 32'(be0_out), 32'(st.pci_select_strap & pci_be0_out));
      check("cs oe", 32'(cs_oe), 32'(e_v.eeprom));
      check("cs out", 32'(cs_out), 32'(st.pci_select_strap & pci_cs_out));
      check("upper oe idle", 32'(gpio_pin_oe), 32'(oe_x));
      @(posedge ref_clk);
      bus_read(`PPSS_OFS_STATUS, status_exp(st, st.serial2_select_strap), "status");
      en_v = 16'($urandom);
      dir_v = 16'($urandom);
      out_v = 16'($urandom);
      bus_write(`PPSS_OFS_GPIO_EN, {16'($urandom), en_v});
      bus_write(`PPSS_OFS_GPIO_DIR, {16'($urandom), dir_v});
      bus_write(`PPSS_OFS_GPIO_OUT, {16'($urandom), out_v});
      bus_write(`PPSS_OFS_STATUS, 32'($urandom));
      bus_write(8'h40, 32'($urandom));
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      oe_x = st.pci_select_strap ? {pci_gpio_oe, en_v[8:0] & dir_v[8:0]} : en_v & dir_v;
      out_x = st.pci_select_strap ? {pci_gpio_out, out_v[8:0]} : out_v;
      check("gpio oe", 32'(gpio_pin_oe), 32'(oe_x));
      check("gpio out", 32'(gpio_pin_out & oe_x), 32'(out_x & oe_x));
      @(posedge ref_clk);
      bus_read(`PPSS_OFS_GPIO_EN, {16'h0, en_v}, "gpio enable");
      bus_read(`PPSS_OFS_GPIO_DIR, {16'h0, dir_v}, "gpio direction");
      bus_read(`PPSS_OFS_GPIO_OUT, {16'h0, out_v}, "gpio output");
      bus_read(`PPSS_OFS_GPIO_IN, {16'h0, gpio_pin_in}, "gpio input");
      bus_read(8'h40, 32'h0, "unmapped");
      // move every strap; only the serial port 2 and eeprom enables may follow
      want <= ~st;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      e_v = en_exp(st, ~st.serial2_select_strap);
      check("live enables", 32'(periph_enable), 32'(e_v));
      check("live cs oe", 32'(cs_oe), 32'(e_v.eeprom));
      @(posedge ref_clk);
      bus_read(`PPSS_OFS_STATUS, status_exp(st, ~st.serial2_select_strap), "live status");
    end
    give_verdict();
  end
endmodule

`default_nettype wire
